/* File: hw/cnt1_cfg.svh */
// constants for the counter output and frequency divider block
// assumes a single 250 MHz clock and synchronous reset
`ifndef CNT1_CFG_SVH
`define CNT1_CFG_SVH
`define CNT1_WIDTH 24
`define CNT1_PIN_COUNT 10
`define CNT1_PIN_SEL_W 4
`define CNT1_DIV_W 4
`define CNT1_MCLK_HZ 250000000
`define CNT1_TB_FAST_HZ 10000000
`define CNT1_TB_SLOW_HZ 100000
`define CNT1_TB_FAST_CYC (`CNT1_MCLK_HZ / `CNT1_TB_FAST_HZ)
`define CNT1_TB_SLOW_CYC (`CNT1_MCLK_HZ / `CNT1_TB_SLOW_HZ)
`define CNT1_TB_CNT_W 12
`endif

/* File: hw/cnt1_pkg.sv */
// types for the counter output and frequency divider block
// assumes cnt1_cfg.svh supplies the widths
`include "cnt1_cfg.svh"
`default_nettype none
package cnt1_pkg;
   typedef enum logic {
      CNT1_SHAPE_PULSE = 1'b0,
      CNT1_SHAPE_TOGGLE = 1'b1
   } cnt1_shape_t;

   typedef struct packed {
      logic [`CNT1_PIN_SEL_W-1:0] src_sel;
      logic src_fall;
      logic [`CNT1_PIN_SEL_W-1:0] gate_sel;
      logic gate_fall;
      cnt1_shape_t shape;
      logic out_low;
      logic out_en;
      logic dir_pin_en;
      logic dir_up;
   } cnt1_ctrl_t;

   typedef struct packed {
      logic slow_sel;
      logic [`CNT1_DIV_W-1:0] divisor_m1;
      logic invert;
      logic out_en;
   } cnt1_div_ctrl_t;
endpackage
`default_nettype wire

/* File: hw/cnt1_top.sv */
// second general-purpose counter output side and frequency divider
// assumes pins are asynchronous to mclk_in; control bits are static ports
`include "cnt1_cfg.svh"
`default_nettype none
module cnt1_top
   import cnt1_pkg::*;
#(
   parameter int CNT_W = `CNT1_WIDTH,
   parameter int PIN_N = `CNT1_PIN_COUNT
) (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic [PIN_N-1:0] function_pins_in,
   input wire logic shared_direction_pin_in,
   input wire cnt1_ctrl_t ctrl_in,
   input wire cnt1_div_ctrl_t div_ctrl_in,
   input wire logic load_in,
   input wire logic [CNT_W-1:0] load_value_in,
   output logic [CNT_W-1:0] count_out,
   output logic counter1_output_out,
   output logic counter1_output_oe_out,
   output logic divided_clock_output_out,
   output logic divided_clock_output_oe_out,
   output logic shared_direction_pin_free_out
);
   localparam int TB_W = `CNT1_TB_CNT_W;
   localparam int SEL_W = `CNT1_PIN_SEL_W;
   localparam int DIV_W = `CNT1_DIV_W;
   localparam logic [TB_W-1:0] FAST_LAST = TB_W'(`CNT1_TB_FAST_CYC - 1);
   localparam logic [TB_W-1:0] FAST_HALF = TB_W'(`CNT1_TB_FAST_CYC / 2);
   localparam logic [TB_W-1:0] SLOW_LAST = TB_W'(`CNT1_TB_SLOW_CYC - 1);
   localparam logic [TB_W-1:0] SLOW_HALF = TB_W'(`CNT1_TB_SLOW_CYC / 2);
   localparam logic [TB_W-1:0] TB_ONE = TB_W'(1);
   localparam logic [SEL_W-1:0] SEL_FAST = SEL_W'(PIN_N);
   localparam logic [SEL_W-1:0] SEL_SLOW = SEL_W'(PIN_N + 1);
   localparam logic [CNT_W-1:0] CNT_TOP = {CNT_W{1'b1}};
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
   localparam logic [DIV_W-1:0] DIV_ONE = DIV_W'(1);

   // pin synchroniser stages
   logic [PIN_N-1:0] pin_s1_r;
   logic [PIN_N-1:0] pin_s2_r;
   logic dir_s1_r;
   logic dir_s2_r;
   // internal timebases
   logic [TB_W-1:0] fast_cnt_r;
   logic [TB_W-1:0] fast_cnt_nxt;
   logic [TB_W-1:0] slow_cnt_r;
   logic [TB_W-1:0] slow_cnt_nxt;
   logic fast_lvl;
   logic slow_lvl;
   // counter path
   logic src_lvl;
   logic gate_lvl;
   logic src_d_r;
   logic src_edge;
   logic gate_on;
   logic count_up;
   logic at_tc;
   logic cnt_step;
   logic tc_hit;
   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] count_nxt;
   logic [CNT_W-1:0] count_stepped;
   logic tc_pulse_r;
   logic tc_pulse_nxt;
   logic tc_toggle_r;
   logic tc_toggle_nxt;
   logic shaped;
   logic co_r;
   logic co_nxt;
   logic co_oe_r;
   logic free_r;
   // divider path
   logic div_lvl;
   logic div_tick;
   logic div_wrap;
   logic [DIV_W-1:0] div_cnt_r;
   logic [DIV_W-1:0] div_cnt_nxt;
   logic dco_r;
   logic dco_nxt;
   logic dco_oe_r;

   function automatic logic pick_line(input logic [PIN_N-1:0] pins, input logic [SEL_W-1:0] sel,
      input logic fast, input logic slow);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < PIN_N; i++) begin
         if (sel == SEL_W'(i)) begin
            hit = pins[i];
         end
      end
      if (sel == SEL_FAST) begin
         hit = fast;
      end
      if (sel == SEL_SLOW) begin
         hit = slow;
      end
      return hit;
   endfunction

   function automatic logic edge_seen(input logic prev, input logic now, input logic fall);
      return fall ? (prev & ~now) : (~prev & now);
   endfunction

   // timebase square waves
   assign fast_cnt_nxt = (fast_cnt_r >= FAST_LAST) ? '0 : fast_cnt_r + TB_ONE;
   assign slow_cnt_nxt = (slow_cnt_r >= SLOW_LAST) ? '0 : slow_cnt_r + TB_ONE;
   assign fast_lvl = fast_cnt_r < FAST_HALF;
   assign slow_lvl = slow_cnt_r < SLOW_HALF;

   assign src_lvl = pick_line(pin_s2_r, ctrl_in.src_sel, fast_lvl, slow_lvl);
   assign gate_lvl = pick_line(pin_s2_r, ctrl_in.gate_sel, fast_lvl, slow_lvl);
   assign src_edge = edge_seen(src_d_r, src_lvl, ctrl_in.src_fall);
   assign gate_on = gate_lvl ^ ctrl_in.gate_fall;
   assign count_up = ctrl_in.dir_pin_en ? dir_s2_r : ctrl_in.dir_up;
   assign at_tc = count_up ? (count_r == CNT_TOP) : (count_r == '0);
   assign cnt_step = src_edge & gate_on & ~load_in;
   assign tc_hit = cnt_step & at_tc;
   // up on high, down on low
   assign count_stepped = count_up ? count_r + CNT_ONE : count_r - CNT_ONE;
   assign count_nxt = load_in ? load_value_in : (cnt_step ? count_stepped : count_r);
   assign tc_pulse_nxt = src_edge ? tc_hit : tc_pulse_r;
   assign tc_toggle_nxt = tc_toggle_r ^ tc_hit;
   assign shaped = (ctrl_in.shape == CNT1_SHAPE_TOGGLE) ? tc_toggle_r : tc_pulse_r;
   assign co_nxt = shaped ^ ctrl_in.out_low;

   assign div_lvl = div_ctrl_in.slow_sel ? slow_lvl : fast_lvl;
   assign div_tick = div_ctrl_in.slow_sel ? (slow_cnt_r == SLOW_HALF) : (fast_cnt_r == FAST_HALF);
   // counts 0 to divisor minus one
   assign div_wrap = div_cnt_r >= div_ctrl_in.divisor_m1;
   assign div_cnt_nxt = !div_tick ? div_cnt_r : (div_wrap ? '0 : div_cnt_r + DIV_ONE);
   assign dco_nxt = ((div_cnt_r == '0) & div_lvl) ^ div_ctrl_in.invert;

   always_ff @(posedge mclk_in) begin
      pin_s1_r <= function_pins_in;
      pin_s2_r <= pin_s1_r;
   end

   always_ff @(posedge mclk_in) begin
      dir_s1_r <= shared_direction_pin_in;
      dir_s2_r <= dir_s1_r;
   end

   // source history, no reset so no false edge
   always_ff @(posedge mclk_in) begin
      src_d_r <= src_lvl;
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         fast_cnt_r <= '0;
         slow_cnt_r <= '0;
      end else begin
         fast_cnt_r <= fast_cnt_nxt;
         slow_cnt_r <= slow_cnt_nxt;
      end
   end

   // counter state
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         count_r <= '0;
         tc_pulse_r <= 1'b0;
         tc_toggle_r <= 1'b0;
      end else begin
         count_r <= count_nxt;
         tc_pulse_r <= tc_pulse_nxt;
         tc_toggle_r <= tc_toggle_nxt;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         co_r <= 1'b0;
         co_oe_r <= 1'b0;
         free_r <= 1'b1;
         div_cnt_r <= '0;
         dco_r <= 1'b0;
         dco_oe_r <= 1'b0;
      end else begin
         co_r <= co_nxt;
         co_oe_r <= ctrl_in.out_en;
         free_r <= ~ctrl_in.dir_pin_en;
         div_cnt_r <= div_cnt_nxt;
         dco_r <= dco_nxt;
         dco_oe_r <= div_ctrl_in.out_en;
      end
   end

   assign count_out = count_r;
   assign counter1_output_out = co_r;
   assign counter1_output_oe_out = co_oe_r;
   assign divided_clock_output_out = dco_r;
   assign divided_clock_output_oe_out = dco_oe_r;
   assign shared_direction_pin_free_out = free_r;

   a_oe_at_start: assert property (
      @(posedge mclk_in) $past(rst_in) |-> !counter1_output_oe_out && !divided_clock_output_oe_out)
      else $error("output enable set straight after reset");

   a_pin_free: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      !$past(rst_in) |-> shared_direction_pin_free_out == !$past(ctrl_in.dir_pin_en))
      else $error("shared pin free flag wrong");

   a_count_up: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      cnt_step && count_up |=> count_out == $past(count_r) + CNT_ONE)
      else $error("count did not step up");

   a_count_down: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      cnt_step && !count_up |=> count_out == $past(count_r) - CNT_ONE)
      else $error("count did not step down");

   a_gate_blocks: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      src_edge && !gate_on && !load_in |=> $stable(count_out))
      else $error("count moved with gate off");

   a_pulse_holds: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      tc_pulse_r && !src_edge |=> tc_pulse_r)
      else $error("pulse ended before next source edge");

   a_pulse_ends: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      tc_pulse_r && src_edge && !tc_hit |=> !tc_pulse_r)
      else $error("pulse outlived one source period");

   a_div_wrap: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      div_tick && div_wrap |=> div_cnt_r == '0)
      else $error("divider did not wrap");
endmodule
`default_nettype wire

/* File: bench/cnt1_pins.sv */
// pin sources facing the counter block
// assumes one slow square wave on every pin
`default_nettype none
module cnt1_pins(input wire logic clk_in, output logic [9:0] pins_out);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] div_r = 4'h0;
   always_ff @(posedge clk_in) div_r <= div_r + 4'h1;
   assign pins_out = {10{div_r[3]}};
endmodule
`default_nettype wire

/* File: bench/cnt1_top_bench.sv */
// bench for the counter output block
// assumes static control ports, 250 MHz clock
`default_nettype none
module cnt1_top_bench import cnt1_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_in = 1'b0, rst_in = 1'b1, ld = 1'b0, sdp = 1'b0, co, coe, dco, dcoe, fr;
   logic [9:0] pins;
   logic [23:0] lv = 24'h0;
   logic [23:0] cnt;
   logic [31:0] lf = 32'h2b4b;
   cnt1_ctrl_t ctrl = '0;
   cnt1_div_ctrl_t dc = '0;
   int fails = 0, n_checks = 0, cyc = 0;
   always #2 mclk_in = ~mclk_in;
   cnt1_pins u_pins(.clk_in(mclk_in), .pins_out(pins));
   cnt1_top u_dut(.mclk_in(mclk_in), .rst_in(rst_in), .function_pins_in(pins), .shared_direction_pin_in(sdp),
      .ctrl_in(ctrl), .div_ctrl_in(dc), .load_in(ld), .load_value_in(lv), .count_out(cnt),
      .counter1_output_out(co), .counter1_output_oe_out(coe), .divided_clock_output_out(dco),
      .divided_clock_output_oe_out(dcoe), .shared_direction_pin_free_out(fr));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], ^(x & 32'h80200003)};
   endfunction
   function automatic logic [23:0] next_count(input logic [23:0] v, input logic up);
      return up ? v + 24'h1 : v - 24'h1;
   endfunction
   function automatic logic at_end(input logic [23:0] v, input logic up);
      return up ? (v == 24'hffffff) : (v == 24'h0);
   endfunction
   function automatic int div_period(input logic slow, input logic [3:0] m1);
      return (slow ? 2500 : 25) * (int'(m1) + 1);
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         $display("wrong value at %0t: %h %h", $time, seen, exp);
         fails++;
      end
   endtask
   task automatic final_report();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic run_cnt(input cnt1_ctrl_t c, input logic pin_v, input logic [23:0] start);
      logic [23:0] v;
      logic up, prev, tc, gon;
      v = start;
      up = c.dir_pin_en ? pin_v : c.dir_up;
      gon = ~c.src_fall ^ c.gate_fall;
      if (c.src_fall) @(negedge pins[0]);
      else @(posedge pins[0]);
      repeat (8) @(posedge mclk_in);
      ctrl <= c;
      sdp <= pin_v;
      ld <= 1'b1;
      lv <= start;
      @(posedge mclk_in);
      ld <= 1'b0;
      repeat (4) @(posedge mclk_in);
      #1 prev = co;
      repeat (4) begin
         if (c.src_fall) @(negedge pins[0]);
         else @(posedge pins[0]);
         repeat (8) @(posedge mclk_in);
         #1 tc = gon & at_end(v, up);
         if (gon) v = next_count(v, up);
         check({8'h0, cnt}, {8'h0, v});
         if (c.shape == CNT1_SHAPE_PULSE) check({31'h0, co}, {31'h0, tc ^ c.out_low});
         else check({31'h0, co}, {31'h0, prev ^ tc});
         prev = co;
      end
   endtask
   task automatic run_div(input logic slow, input logic [3:0] m1, input logic inv);
      longint t0;
      @(posedge mclk_in);
      dc <= '{slow_sel: slow, divisor_m1: m1, invert: inv, out_en: 1'b1};
      repeat (3) begin
         if (inv) @(negedge dco);
         else @(posedge dco);
      end
      t0 = $time;
      if (inv) @(negedge dco);
      else @(posedge dco);
      check(32'(($time - t0) / 4), 32'(div_period(slow, m1)));
   endtask
   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 40000) begin
         fails++;
         final_report();
      end
   end
   initial begin
      cnt1_ctrl_t c;
      repeat (5) @(posedge mclk_in);
      rst_in <= 1'b0;
      repeat (3) @(posedge mclk_in);
      #1 check({30'h0, coe, dcoe}, 32'h0);
      repeat (40) begin
         @(posedge mclk_in);
         lf = lfsr(lf);
         {ctrl.dir_pin_en, ctrl.out_en, dc.out_en, ld, sdp} <= lf[4:0];
         lv <= lf[31:8];
         repeat (4) @(posedge mclk_in);
         #1 check({31'h0, fr}, {31'h0, ~lf[4]});
         check({30'h0, coe, dcoe}, {30'h0, lf[3:2]});
      end
      @(posedge mclk_in);
      ld <= 1'b0;
      c = '{src_sel: 4'h0, src_fall: 1'b0, gate_sel: 4'h5, gate_fall: 1'b0,
         shape: CNT1_SHAPE_PULSE, out_low: 1'b0, out_en: 1'b1, dir_pin_en: 1'b0, dir_up: 1'b1};
      run_cnt(c, 1'b0, 24'hfffffd);
      c.src_fall = 1'b1;
      c.gate_fall = 1'b1;
      c.shape = CNT1_SHAPE_TOGGLE;
      c.out_low = 1'b1;
      c.dir_pin_en = 1'b1;
      run_cnt(c, 1'b0, 24'h000002);
      c.src_fall = 1'b0;
      c.gate_fall = 1'b0;
      c.shape = CNT1_SHAPE_PULSE;
      c.dir_up = 1'b0;
      run_cnt(c, 1'b1, 24'hfffffe);
      c.dir_pin_en = 1'b0;
      c.gate_fall = 1'b1;
      run_cnt(c, 1'b0, 24'h123456);
      repeat (3) begin
         lf = lfsr(lf);
         c.src_sel = 4'h3;
         c.gate_sel = 4'h7;
         c.src_fall = lf[0];
         c.gate_fall = lf[1];
         c.shape = cnt1_shape_t'(lf[2]);
         c.out_low = lf[3];
         c.dir_pin_en = lf[4];
         c.dir_up = lf[5];
         run_cnt(c, lf[6], lf[7] ? {22'h3fffff, lf[9:8]} : {22'h0, lf[9:8]});
      end
      run_div(1'b0, 4'h0, 1'b0);
      run_div(1'b0, 4'hf, 1'b1);
      run_div(1'b1, 4'h0, 1'b0);
      repeat (2) begin
         lf = lfsr(lf);
         run_div(1'b0, lf[3:0], lf[4]);
      end
      final_report();
   end
endmodule
`default_nettype wire
